/* hdl/adc_ctl_pkg.sv */
package adc_ctl_pkg;

    // ------------------------------------------------------------
    // Bus and register map
    // ------------------------------------------------------------
    localparam int           ADDR_W         = 8;
    localparam int           DATA_W         = 32;
    localparam logic [7:0]   OFF_CTL0       = 8'h00;
    localparam logic [7:0]   OFF_CTL1       = 8'h04;
    localparam logic [7:0]   OFF_RES_HI     = 8'h08;
    localparam logic [7:0]   OFF_RES_LO     = 8'h0C;
    localparam logic [7:0]   OFF_IRQ_STAT   = 8'h10;
    localparam logic [7:0]   OFF_IRQ_MASK   = 8'h14;
    localparam logic [7:0]   OFF_PIN_AF     = 8'h18;

    // ------------------------------------------------------------
    // Control register 0 fields
    // ------------------------------------------------------------
    localparam int           C0_START_BIT   = 7;
    localparam int           C0_REFSEL_L    = 6;
    localparam int           C0_REFPIN_BIT  = 5;
    localparam int           C0_CONT_BIT    = 4;
    localparam int           C0_MUX_MSB     = 3;

    // ------------------------------------------------------------
    // Control/status register 1 fields
    // ------------------------------------------------------------
    localparam int           C1_REFSEL_H    = 7;
    localparam int           C1_BUSY_BIT    = 6;
    localparam int           C1_PWR_BIT     = 5;
    localparam int           C1_BUF_MSB     = 2;

    localparam logic [3:0]   MUX_TEMP       = 4'h8;
    localparam logic         BUF_DIFF_BIT_V = 1'b1;
    localparam int           BUF_DIFF_BIT   = 2;
    localparam logic [3:0]   RES_BITS_DIFF  = 4'hB;
    localparam logic [3:0]   RES_BITS_SE    = 4'hA;
    localparam int           RESULT_W       = 13;
    localparam int           LO_PAD_W       = 3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int           CLK_MHZ        = 125;
    localparam int           CONV_CYCLES    = 5129;
    localparam int           PWRUP_CYCLES   = 40;
    localparam int           IDLE_CYCLES    = 160;
    localparam int           CNT_W          = 13;

    typedef enum logic [1:0] {ST_IDLE, ST_PWRUP, ST_CONV} adc_state_e;

endpackage

/* hdl/adc_ctl.sv */
`timescale 1ns/100ps
module adc_ctl
    import adc_ctl_pkg::*;
(
    // Clock and reset
    input  wire logic                         ref_clk,
    input  wire logic                         rst_b,
    // APB slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [adc_ctl_pkg::ADDR_W-1:0] paddr,
    input  wire logic [adc_ctl_pkg::DATA_W-1:0] pwdata,
    output logic      [adc_ctl_pkg::DATA_W-1:0] prdata,
    output logic                              pready,
    output logic                              pslverr,
    // Modulator / filter side
    input  wire logic                         filt_valid,
    input  wire logic [12:0]                  filt_data,
    // Analog controls
    output logic                              adc_power_on,
    output logic                              convert_run,
    output logic [3:0]                        input_select,
    output logic [2:0]                        input_buffer_config,
    output logic [1:0]                        reference_select,
    output logic                              reference_pin_output,
    output logic [3:0]                        resolution_bits,
    output logic [7:0]                        pin_digital_disable,
    // Interrupt
    output logic                              irq
);
    import adc_ctl_pkg::*;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    adc_state_e        state_q, state_d;
    logic [CNT_W-1:0]  cnt_q, cnt_d;
    logic [7:0]        idle_q, idle_d;
    logic              pwr_q, pwr_d;
    logic              start_q, start_d;
    logic              cont_q, refsel_l_q, refsel_h_q, refpin_q;
    logic [3:0]        mux_q;
    logic [2:0]        buf_q;
    logic [7:0]        res_hi_q, res_lo_q;
    logic              stat_q, mask_q;
    logic [7:0]        pin_af_q;
    logic [12:0]       sample_q;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Full byte-address compare; no aliasing of unmapped words
    function automatic logic addr_hit
    (
        input logic [ADDR_W-1:0] addr,
        input logic [7:0]        offset
    );
        return addr == offset;
    endfunction

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // Write lands at the edge where the master samples pready high
    wire        wr_en   = psel && penable && pwrite && pready;
    wire        rd_en   = psel && !penable;
    wire        hit_c0  = addr_hit(paddr, OFF_CTL0);
    wire        hit_c1  = addr_hit(paddr, OFF_CTL1);
    wire        hit_hi  = addr_hit(paddr, OFF_RES_HI);
    wire        hit_lo  = addr_hit(paddr, OFF_RES_LO);
    wire        hit_st  = addr_hit(paddr, OFF_IRQ_STAT);
    wire        hit_mk  = addr_hit(paddr, OFF_IRQ_MASK);
    wire        hit_af  = addr_hit(paddr, OFF_PIN_AF);
    wire        mapped  = hit_c0 | hit_c1 | hit_hi | hit_lo | hit_st | hit_mk | hit_af;
    wire        start_wr = wr_en && hit_c0 && pwdata[C0_START_BIT];
    wire        done     = (state_q == ST_CONV) && (cnt_q == CNT_W'(CONV_CYCLES - 1));
    // Filter output is captured continuously; its latency spans several samples
    wire [12:0] result   = sample_q;

    wire [7:0]  ctl0_rd = {start_q, refsel_l_q, refpin_q, cont_q, mux_q};
    wire [7:0]  ctl1_rd = {refsel_h_q, (state_q != ST_IDLE), pwr_q, 2'h0, buf_q};
    wire [7:0]  rd_mux  = hit_c0 ? ctl0_rd :
                          hit_c1 ? ctl1_rd :
                          hit_hi ? res_hi_q :
                          hit_lo ? res_lo_q :
                          hit_st ? {7'h00, stat_q} :
                          hit_mk ? {7'h00, mask_q} :
                          hit_af ? pin_af_q : 8'h00;

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        start_d = start_q;
        pwr_d   = pwr_q;
        idle_d  = idle_q;
        if (start_wr)
            start_d = 1'b1;
        unique case (state_q)
            ST_IDLE:
            begin
                cnt_d = '0;
                if (start_q)
                begin
                    state_d = pwr_q ? ST_CONV : ST_PWRUP;
                    pwr_d   = 1'b1;
                    idle_d  = '0;
                end
                else if (pwr_q)
                begin
                    idle_d = idle_q + 8'h01;
                    if (idle_q == 8'(IDLE_CYCLES - 1))
                    begin
                        pwr_d  = 1'b0;
                        idle_d = '0;
                    end
                end
            end
            ST_PWRUP:
            begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == CNT_W'(PWRUP_CYCLES - 1))
                begin
                    cnt_d   = '0;
                    state_d = ST_CONV;
                end
            end
            ST_CONV:
            begin
                cnt_d = cnt_q + 1'b1;
                if (done)
                begin
                    cnt_d = '0;
                    if (cont_q)
                        state_d = ST_CONV;
                    else
                    begin
                        state_d = ST_IDLE;
                        start_d = start_wr;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= ST_IDLE;
            cnt_q   <= '0;
            idle_q  <= '0;
            pwr_q   <= 1'b0;
            start_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            idle_q  <= idle_d;
            pwr_q   <= pwr_d;
            start_q <= start_d;
        end
    end

    // ------------------------------------------------------------
    // Result, configuration and interrupt
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            sample_q <= '0;
        else if (filt_valid)
            sample_q <= filt_data;
    end

    // Data bytes change only at completion, so both bytes come from one result
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            res_hi_q <= '0;
            res_lo_q <= '0;
        end
        else if (done)
        begin
            res_hi_q <= result[12:5];
            res_lo_q <= {result[4:0], LO_PAD_W'(0)};
        end
    end

    // ------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------
    // Set wins over a same-cycle write-one clear
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            stat_q <= 1'b0;
        else if (done)
            stat_q <= 1'b1;
        else if (wr_en && hit_st && pwdata[0])
            stat_q <= 1'b0;
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            mask_q <= 1'b0;
        else if (wr_en && hit_mk)
            mask_q <= pwdata[0];
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    // Start bit is handled by the sequencer; only a one has effect there
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cont_q     <= 1'b0;
            refsel_l_q <= 1'b0;
            refpin_q   <= 1'b0;
            mux_q      <= '0;
        end
        else if (wr_en && hit_c0)
        begin
            cont_q     <= pwdata[C0_CONT_BIT];
            refsel_l_q <= pwdata[C0_REFSEL_L];
            refpin_q   <= pwdata[C0_REFPIN_BIT];
            mux_q      <= pwdata[C0_MUX_MSB:0];
        end
    end

    // Busy and power bits of this word are read-only
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            refsel_h_q <= 1'b0;
            buf_q      <= '0;
        end
        else if (wr_en && hit_c1)
        begin
            refsel_h_q <= pwdata[C1_REFSEL_H];
            buf_q      <= pwdata[C1_BUF_MSB:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            pin_af_q <= '0;
        else if (wr_en && hit_af)
            pin_af_q <= pwdata[7:0];
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    // No wait states: answer in the cycle after the setup phase
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (rd_en)
                prdata <= {24'h000000, rd_mux};
        end
    end

    // Taken from the next-state values so the pins match the state register
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            adc_power_on <= 1'b0;
            convert_run  <= 1'b0;
        end
        else
        begin
            adc_power_on <= pwr_d;
            convert_run  <= (state_d == ST_CONV);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            input_select         <= '0;
            input_buffer_config  <= '0;
            reference_select     <= '0;
            reference_pin_output <= 1'b0;
            pin_digital_disable  <= '0;
        end
        else
        begin
            input_select         <= mux_q;
            input_buffer_config  <= buf_q;
            reference_select     <= {refsel_h_q, refsel_l_q};
            reference_pin_output <= refpin_q;
            pin_digital_disable  <= pin_af_q;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            resolution_bits <= RES_BITS_SE;
        else
            resolution_bits <= (buf_q[BUF_DIFF_BIT] == BUF_DIFF_BIT_V) ? RES_BITS_DIFF : RES_BITS_SE;
    end

    // Level output, one cycle behind the status bit
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            irq <= 1'b0;
        else
            irq <= stat_q && mask_q;
    end

endmodule

/* dv/adc_ctl_sva.sv */
`timescale 1ns/100ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module adc_ctl_sva
    import adc_ctl_pkg::*;
(
    // Clock and reset
    input wire logic                           ref_clk,
    input wire logic                           rst_b,
    // Bus
    input wire logic                           psel,
    input wire logic                           penable,
    input wire logic                           pready,
    input wire logic                           pslverr,
    input wire logic [adc_ctl_pkg::DATA_W-1:0] prdata,
    // Converter
    input wire logic                           adc_power_on,
    input wire logic                           convert_run,
    input wire logic [2:0]                     input_buffer_config,
    input wire logic [3:0]                     resolution_bits
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // Modulo count, since continuous mode may keep run high across results
    logic [12:0] run_q;
    logic [8:0]  idle_q;
    always_ff @(posedge ref_clk or negedge rst_b)
        if (!rst_b) run_q <= '0;
        else run_q <= (!convert_run || run_q == 13'(CONV_CYCLES - 1)) ? 13'h0 : run_q + 13'h1;
    always_ff @(posedge ref_clk or negedge rst_b)
        if (!rst_b) idle_q <= '0;
        else idle_q <= (adc_power_on && !convert_run) ? idle_q + 9'h1 : 9'h0;

    a_setup_ready: assert property (psel && !penable |=> pready) else $error("no pready after setup");
    a_ready_access: assert property (pready |-> psel && penable) else $error("pready outside access");
    a_error_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
    a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0) else $error("prdata upper bits set");
    a_run_powered: assert property (convert_run |-> adc_power_on) else $error("run while off");
    a_powerup_delay: assert property ($rose(adc_power_on) |-> ##[39:41] $rose(convert_run))
        else $error("power-up delay wrong");
    a_conv_length: assert property ($fell(convert_run) |-> run_q == 13'h0) else $error("bad length");
    a_idle_off: assert property (idle_q <= 9'(IDLE_CYCLES + 1)) else $error("no power-down");
    a_res_mode: assert property ($stable(input_buffer_config) |->
        resolution_bits == (input_buffer_config[BUF_DIFF_BIT] ? RES_BITS_DIFF : RES_BITS_SE)) else $error("bad res");
endmodule
bind adc_ctl adc_ctl_sva i_adc_ctl_sva (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .adc_power_on(adc_power_on), .convert_run(convert_run),
    .input_buffer_config(input_buffer_config), .resolution_bits(resolution_bits));

/* dv/filt_model.sv */
`timescale 1ns/100ps
module filt_model
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    // Sample from the bench, filter output
    input  wire logic [12:0] sample,
    output logic             filt_valid,
    output logic [12:0]      filt_data
);
    logic [2:0] tick_q;
    // Data flips between strobes so a latch off the strobe shows up
    always_ff @(posedge ref_clk or negedge rst_b)
        if (!rst_b) {tick_q, filt_valid, filt_data} <= '0;
        else {tick_q, filt_valid, filt_data} <= {tick_q + 3'h1, tick_q == 3'h7, tick_q == 3'h7 ? sample : ~filt_data};
endmodule

/* dv/test_sigma_delta_adc_conversion_control.sv */
`timescale 1ns/100ps
module test_sigma_delta_adc_conversion_control;
    import adc_ctl_pkg::*;
    logic        ref_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err_q;
    logic [7:0]  paddr = '0, pin_digital_disable;
    logic [31:0] pwdata = '0, prdata, r, v;
    logic [12:0] smp = '0, filt_data;
    logic [3:0]  input_select, resolution_bits;
    logic [2:0]  input_buffer_config;
    logic [1:0]  reference_select;
    logic        pready, pslverr, filt_valid, adc_power_on, convert_run, reference_pin_output, irq;
    int          miscompares = 0, compares = 0, n;

    initial
    begin
        forever #4 ref_clk = ~ref_clk;
    end
    filt_model i_filt_model (.ref_clk(ref_clk), .rst_b(rst_b), .sample(smp), .filt_valid(filt_valid),
        .filt_data(filt_data));
    adc_ctl i_adc_ctl (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .filt_valid(filt_valid), .filt_data(filt_data), .adc_power_on(adc_power_on), .convert_run(convert_run),
        .input_select(input_select), .input_buffer_config(input_buffer_config), .reference_select(reference_select),
        .reference_pin_output(reference_pin_output), .resolution_bits(resolution_bits),
        .pin_digital_disable(pin_digital_disable), .irq(irq));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        miscompares += int'(got !== exp);
        if (got !== exp) $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        {r, err_q} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(r, e);
    endtask
    task automatic clr();
        apb(1'b1, OFF_IRQ_STAT, 32'h1);
        repeat (2) @(posedge ref_clk);
        chk(32'(irq), 32'h0);
    endtask
    task automatic wait_irq();
        for (n = 0; irq !== 1'b1; n++) @(posedge ref_clk);
    endtask
    function automatic int conv_len(input logic off);
        return CONV_CYCLES + (off ? PWRUP_CYCLES : 0);
    endfunction
    function automatic logic [31:0] lo_exp(input logic [12:0] s);
        return {24'h0, s[4:0], 3'h0};
    endfunction
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        repeat (60000) @(posedge ref_clk);
        miscompares++;
        give_verdict();
    end

    initial
    begin
        void'($urandom(58178));
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        rd(OFF_CTL0, 32'h0);
        rd(OFF_CTL1, 32'h0);
        apb(1'b0, 8'h1C, 32'h0);
        chk({r[27:0], resolution_bits}, 32'hA);
        chk(32'(err_q), 32'h1);
        $display("Test reset done");
        for (int i = 0; i < 8; i++)
        begin
            v = $urandom;
            v[6] = v[6] | v[5];
            apb(1'b1, OFF_CTL1, {24'h0, v[7], 4'h0, 3'(i)});
            apb(1'b1, OFF_CTL0, {25'h0, v[6:5], 1'b0, v[3:0]});
            apb(1'b1, OFF_PIN_AF, {24'h0, v[15:8]});
            repeat (2) @(posedge ref_clk);
            chk(32'({input_buffer_config, resolution_bits, reference_select, reference_pin_output, input_select,
                pin_digital_disable}), 32'({3'(i), i[2] ? 4'hB : 4'hA, v[7:5], v[3:0], v[15:8]}));
        end
        $display("Test config done");
        v = $urandom;
        smp <= v[12:0];
        apb(1'b1, OFF_IRQ_MASK, 32'h1);
        apb(1'b1, OFF_CTL0, 32'h80);
        rd(OFF_CTL0, 32'h80);
        wait_irq();
        chk(32'(n > conv_len(1) - 8 && n < conv_len(1) + 4), 32'h1);
        rd(OFF_RES_HI, {24'h0, v[12:5]});
        rd(OFF_RES_LO, lo_exp(v[12:0]));
        rd(OFF_CTL0, 32'h0);
        clr();
        $display("Test single done");
        apb(1'b1, OFF_IRQ_MASK, 32'h0);
        apb(1'b1, OFF_CTL0, 32'h80);
        rd(OFF_CTL0, 32'h80);
        for (n = 0; r[7] === 1'b1; n++) apb(1'b0, OFF_CTL0, 32'h0);
        chk(32'(3 * n > conv_len(0) - 12 && 3 * n < conv_len(0) + 9), 32'h1);
        chk(32'(irq), 32'h0);
        rd(OFF_IRQ_STAT, 32'h1);
        apb(1'b1, OFF_IRQ_MASK, 32'h1);
        repeat (2) @(posedge ref_clk);
        chk(32'(irq), 32'h1);
        clr();
        $display("Test masked done");
        apb(1'b1, OFF_CTL0, 32'h90);
        for (int k = 0; k < 2; k++)
        begin
            v = $urandom;
            smp <= v[12:0];
            wait_irq();
            chk(32'(n < CONV_CYCLES + 4), 32'h1);
            rd(OFF_RES_HI, {24'h0, v[12:5]});
            rd(OFF_RES_LO, lo_exp(v[12:0]));
            rd(OFF_CTL0, 32'h90);
            clr();
        end
        apb(1'b1, OFF_CTL0, 32'h0);
        wait_irq();
        clr();
        // Idle time runs from the end of the last conversion
        repeat (IDLE_CYCLES - 20) @(posedge ref_clk);
        chk(32'(adc_power_on), 32'h1);
        repeat (40) @(posedge ref_clk);
        chk(32'(adc_power_on), 32'h0);
        $display("Test continuous done");
        give_verdict();
    end
endmodule
